// ### ctrdec_top.sv
// ctrdec_top.sv - command decoder and five 16-bit counters behind APB
// assumes: one 25 MHz clock, inputs synchronous to it, APB master
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ns

module ctrdec_top #(
   parameter int NUM_CTR = 5
) (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 resetn,
   // apb slave
   input  wire logic [7:0]           paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // counter inputs
   input  wire logic [NUM_CTR-1:0]   src_edge,
   input  wire logic [NUM_CTR-1:0]   gate_in,
   // counter and decoder outputs
   output logic      [NUM_CTR-1:0]   ctr_out,
   output logic                      pointer_autoadvance_off,
   output ctrdec_pkg::ctrdec_dptr_s  dptr
);
   import ctrdec_pkg::*;

   // ==========================================================
   // bus decode
   logic        acc;
   logic        wr;
   logic [3:0]  slot;
   logic [1:0]  word;
   logic        slot_ok;
   logic        glob_ok;

   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign slot    = paddr[7:4];
   assign word    = paddr[3:2];
   assign slot_ok = (slot >= 4'h1) && (slot <= 4'(NUM_CTR))
                    && (paddr[1:0] == 2'b00);
   assign glob_ok = (slot == 4'h0) && (paddr[1:0] == 2'b00);
   assign pready  = 1'b1;
   // unmapped addresses answer with an error
   assign pslverr = acc & ~(slot_ok | glob_ok);

   // ==========================================================
   // command decode
   logic [7:0]   cmd;
   logic         cmd_wr;
   ctrdec_cmd_e  cls;
   logic [2:0]   num;

   assign cmd_wr = wr && glob_ok && (paddr[3:2] == 2'(`CTRDEC_OFS_CMD >> 2));
   assign cmd    = pwdata[7:0];
   assign num    = cmd[2:0];

   // opcode to command class
   always_comb begin
      cls = CTRDEC_NONE;
      if (cmd_wr) begin
         case (cmd[7:5])
            `CTRDEC_OP_PTR: begin
               if (cmd[2:0] != `CTRDEC_GRP_BAD_A &&
                   cmd[2:0] != `CTRDEC_GRP_BAD_B) begin
                  cls = CTRDEC_LDPTR;
               end
            end
            `CTRDEC_OP_ARM:     cls = CTRDEC_ARM;
            `CTRDEC_OP_LOAD:    cls = CTRDEC_LOAD;
            `CTRDEC_OP_LDARM:   cls = CTRDEC_LDARM;
            `CTRDEC_OP_DISSAVE: cls = CTRDEC_DISSAVE;
            `CTRDEC_OP_SAVE:    cls = CTRDEC_SAVE;
            `CTRDEC_OP_DISARM:  cls = CTRDEC_DISARM;
            `CTRDEC_OP_MISC: begin
               case (cmd[4:3])
                  `CTRDEC_SUB_SETTOG: begin
                     if (num == `CTRDEC_NUM_NONE) begin
                        cls = CTRDEC_SEQOFF;
                     end else if (num <= `CTRDEC_NUM_LAST) begin
                        cls = CTRDEC_SETTOG;
                     end
                  end
                  `CTRDEC_SUB_CLRTOG: begin
                     if (num == `CTRDEC_NUM_NONE) begin
                        cls = CTRDEC_SEQON;
                     end else if (num <= `CTRDEC_NUM_LAST) begin
                        cls = CTRDEC_CLRTOG;
                     end
                  end
                  `CTRDEC_SUB_STEP: begin
                     if (num != `CTRDEC_NUM_NONE &&
                         num <= `CTRDEC_NUM_LAST) begin
                        cls = CTRDEC_STEP;
                     end
                  end
                  default: cls = CTRDEC_NONE;
               endcase
            end
            default: cls = CTRDEC_NONE;
         endcase
      end
   end

   // ==========================================================
   // master mode register
   logic [15:0] mmode_q;
   logic        mm_wr;

   assign mm_wr = wr && glob_ok && (paddr[3:2] == 2'(`CTRDEC_OFS_MMODE >> 2));

   // single-bit commands touch only the autoadvance-off bit
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mmode_q <= `CTRDEC_MMODE_RST;
      end else if (mm_wr) begin
         mmode_q <= pwdata[15:0];
      end else if (cls == CTRDEC_SEQOFF) begin
         mmode_q[`CTRDEC_MM_AUTOOFF] <= 1'b1;
      end else if (cls == CTRDEC_SEQON) begin
         mmode_q[`CTRDEC_MM_AUTOOFF] <= 1'b0;
      end
   end
   assign pointer_autoadvance_off = mmode_q[`CTRDEC_MM_AUTOOFF];

   // ==========================================================
   // data pointer
   ctrdec_dptr_s dptr_q;

   // element and group copied, byte pointer set
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         dptr_q <= '0;
      end else if (cls == CTRDEC_LDPTR) begin
         dptr_q.element  <= cmd[4:3];
         dptr_q.group    <= cmd[2:0];
         dptr_q.byte_ptr <= 1'b1;
      end
   end
   assign dptr = dptr_q;

   // ==========================================================
   // counters
   logic [15:0]   cnt_q   [NUM_CTR];
   logic [15:0]   load_q  [NUM_CTR];
   logic [15:0]   hold_q  [NUM_CTR];
   ctrdec_cmode_s mode_q  [NUM_CTR];
   logic [NUM_CTR-1:0] armed_q;
   logic [NUM_CTR-1:0] tc_q;
   logic [NUM_CTR-1:0] tog_q;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CTR; gi++) begin : g_ctr
         logic        sel;
         logic        nsel;
         logic        my_wr;
         logic        do_load;
         logic        do_arm;
         logic        do_disarm;
         logic        do_save;
         logic        do_step;
         logic        edge_cnt;
         logic        pre_tc;
         logic        use_hold;
         logic        enter_tc;
         logic        leave_tc;
         logic        alt_q;
         logic        dpend_q;
         logic [15:0] reload;
         logic [15:0] stepped;

         // one select bit per counter, one number per counter
         assign sel   = cmd[gi];
         assign nsel  = (num == 3'(gi + 1));
         assign my_wr = wr && slot_ok && (slot == 4'(gi + 1));

         assign do_load   = (cls == CTRDEC_LOAD || cls == CTRDEC_LDARM)
                            && sel;
         assign do_arm    = (cls == CTRDEC_ARM || cls == CTRDEC_LDARM)
                            && sel;
         assign do_disarm = (cls == CTRDEC_DISARM ||
                             cls == CTRDEC_DISSAVE) && sel;
         assign do_save   = (cls == CTRDEC_SAVE ||
                             cls == CTRDEC_DISSAVE) && sel;
         assign do_step   = (cls == CTRDEC_STEP) && nsel;

         // source edges count only while armed or leaving tc
         assign edge_cnt = src_edge[gi] && (armed_q[gi] || tc_q[gi])
                           && !do_load && !do_step;

         assign pre_tc = mode_q[gi].count_direction_bit
                         ? (cnt_q[gi] == `CTRDEC_CNT_UP_TC)
                         : (cnt_q[gi] == `CTRDEC_CNT_DOWN_TC);

         // reload source by gate, armed state and mode
         always_comb begin
            if (mode_q[gi].gate_reload) begin
               use_hold = gate_in[gi];
            end else if (armed_q[gi]) begin
               use_hold = mode_q[gi].alternate ? alt_q
                                               : mode_q[gi].reload_hold;
            end else begin
               use_hold = 1'b0;
            end
         end
         assign reload  = use_hold ? hold_q[gi] : load_q[gi];
         assign stepped = mode_q[gi].count_direction_bit
                          ? cnt_q[gi] + 16'h0001
                          : cnt_q[gi] - 16'h0001;

         // a load acts as a pseudo-count
         assign enter_tc = !tc_q[gi] && pre_tc
                           && (do_load || edge_cnt);
         assign leave_tc = tc_q[gi]
                           && (do_load || do_step || edge_cnt);

         // counter value
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               cnt_q[gi] <= `CTRDEC_WORD_RST;
            end else if (do_load) begin
               cnt_q[gi] <= reload;
            end else if (do_step) begin
               cnt_q[gi] <= stepped;
            end else if (edge_cnt) begin
               cnt_q[gi] <= enter_tc ? reload : stepped;
            end
         end

         // terminal count state
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               tc_q[gi] <= 1'b0;
            end else if (enter_tc) begin
               tc_q[gi] <= 1'b1;
            end else if (leave_tc) begin
               tc_q[gi] <= 1'b0;
            end
         end

         // alternating reload choice, reset to hold by arm
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               alt_q <= 1'b1;
            end else if (do_arm) begin
               alt_q <= 1'b1;
            end else if (enter_tc && mode_q[gi].alternate) begin
               alt_q <= ~alt_q;
            end
         end

         // deferred disarm while in terminal count
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               dpend_q <= 1'b0;
            end else if (do_arm) begin
               dpend_q <= 1'b0;
            end else if (do_disarm && tc_q[gi] && !leave_tc) begin
               dpend_q <= 1'b1;
            end else if (enter_tc && mode_q[gi].disarm_on_tc) begin
               dpend_q <= 1'b1;
            end else if (leave_tc) begin
               dpend_q <= 1'b0;
            end
         end

         // armed flag; a disarm meeting the count that leaves tc acts now
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               armed_q[gi] <= 1'b0;
            end else if (do_arm) begin
               armed_q[gi] <= 1'b1;
            end else if (do_disarm && (!tc_q[gi] || leave_tc)) begin
               armed_q[gi] <= 1'b0;
            end else if (leave_tc && dpend_q) begin
               armed_q[gi] <= 1'b0;
            end
         end

         // load storage and mode, written by software only
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               load_q[gi] <= `CTRDEC_WORD_RST;
               mode_q[gi] <= `CTRDEC_CMODE_RST;
            end else if (my_wr && word == `CTRDEC_SLOT_LOAD) begin
               load_q[gi] <= pwdata[15:0];
            end else if (my_wr && word == `CTRDEC_SLOT_MODE) begin
               mode_q[gi] <= pwdata[7:0];
            end
         end

         // hold storage, save wins over a software write
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               hold_q[gi] <= `CTRDEC_WORD_RST;
            end else if (do_save) begin
               hold_q[gi] <= cnt_q[gi];
            end else if (my_wr && word == `CTRDEC_SLOT_HOLD) begin
               hold_q[gi] <= pwdata[15:0];
            end
         end

         // toggle flip-flop, flips on each terminal count entry not met by a set/clear toggle command
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               tog_q[gi] <= 1'b0;
            end else if (cls == CTRDEC_SETTOG && nsel) begin
               tog_q[gi] <= 1'b1;
            end else if (cls == CTRDEC_CLRTOG && nsel) begin
               tog_q[gi] <= 1'b0;
            end else if (enter_tc) begin
               tog_q[gi] <= ~tog_q[gi];
            end
         end

         // output select by output-control field
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               ctr_out[gi] <= 1'b0;
            end else begin
               case (mode_q[gi].output_control)
                  `CTRDEC_OC_TOGGLE:  ctr_out[gi] <= tog_q[gi];
                  `CTRDEC_OC_TCPULSE: ctr_out[gi] <= tc_q[gi];
                  default:            ctr_out[gi] <= 1'b0;
               endcase
            end
         end
      end
   endgenerate

   // ==========================================================
   // read mux
   logic [2:0] ridx;
   assign ridx = 3'(slot - 4'h1);

   always_comb begin
      prdata = 32'h0000_0000;
      if (acc && !pwrite && glob_ok) begin
         case (paddr[3:2])
            2'(`CTRDEC_OFS_MMODE >> 2): prdata = {16'h0000, mmode_q};
            2'(`CTRDEC_OFS_DPTR >> 2):  prdata = {26'h000_0000, dptr_q};
            2'(`CTRDEC_OFS_STAT >> 2):
               prdata = {17'h0_0000, tog_q, tc_q, armed_q};
            default:                prdata = 32'h0000_0000;
         endcase
      end else if (acc && !pwrite && slot_ok) begin
         case (word)
            `CTRDEC_SLOT_MODE: prdata = {24'h00_0000, mode_q[ridx]};
            `CTRDEC_SLOT_LOAD: prdata = {16'h0000, load_q[ridx]};
            `CTRDEC_SLOT_HOLD: prdata = {16'h0000, hold_q[ridx]};
            default:           prdata = {16'h0000, cnt_q[ridx]};
         endcase
      end
   end
endmodule

// ### ctrdec_defines.svh
// ctrdec_defines.svh - offsets, field positions, reset values, opcodes
// assumes: included by the package and the design, word-aligned APB map
`ifndef CTRDEC_DEFINES_SVH
`define CTRDEC_DEFINES_SVH

// ==========================================================
// register byte offsets
`define CTRDEC_OFS_CMD      8'h00
`define CTRDEC_OFS_MMODE    8'h04
`define CTRDEC_OFS_DPTR     8'h08
`define CTRDEC_OFS_STAT     8'h0C
// counter n (1..5) sits at n*16; word index within the slot
`define CTRDEC_SLOT_MODE    2'h0
`define CTRDEC_SLOT_LOAD    2'h1
`define CTRDEC_SLOT_HOLD    2'h2
`define CTRDEC_SLOT_CNT     2'h3

// ==========================================================
// command opcode fields
`define CTRDEC_OP_PTR       3'h0
`define CTRDEC_OP_ARM       3'h1
`define CTRDEC_OP_LOAD      3'h2
`define CTRDEC_OP_LDARM     3'h3
`define CTRDEC_OP_DISSAVE   3'h4
`define CTRDEC_OP_SAVE      3'h5
`define CTRDEC_OP_DISARM    3'h6
`define CTRDEC_OP_MISC      3'h7
`define CTRDEC_SUB_CLRTOG   2'h0
`define CTRDEC_SUB_SETTOG   2'h1
`define CTRDEC_SUB_STEP     2'h2
`define CTRDEC_GRP_BAD_A    3'h0
`define CTRDEC_GRP_BAD_B    3'h6
`define CTRDEC_NUM_NONE     3'h0
`define CTRDEC_NUM_LAST     3'h5

// ==========================================================
// field positions and reset values
`define CTRDEC_MM_AUTOOFF   14
`define CTRDEC_OC_TOGGLE    3'h2
`define CTRDEC_OC_TCPULSE   3'h1
`define CTRDEC_MMODE_RST    16'h0000
`define CTRDEC_CMODE_RST    8'h00
`define CTRDEC_WORD_RST     16'h0000
`define CTRDEC_CNT_DOWN_TC  16'h0001
`define CTRDEC_CNT_UP_TC    16'hFFFF

`endif

// ### ctrdec_pkg.sv
// ctrdec_pkg.sv - types shared by the command decoder
// assumes: constants come from ctrdec_defines.svh
package ctrdec_pkg;
`include "ctrdec_defines.svh"

   // ==========================================================
   // counter mode word (low byte of the mode register)
   typedef struct packed {
      logic       disarm_on_tc;  // stop after the terminal count
      logic       gate_reload;   // gate input picks reload source
      logic       alternate;     // reload alternates hold/load
      logic       reload_hold;   // fixed reload from hold storage
      logic       count_direction_bit;
      logic [2:0] output_control;
   } ctrdec_cmode_s;

   // data pointer contents
   typedef struct packed {
      logic       byte_ptr;
      logic [1:0] element;
      logic [2:0] group;
   } ctrdec_dptr_s;

   // decoded command class
   typedef enum logic [3:0] {
      CTRDEC_NONE, CTRDEC_LDPTR, CTRDEC_ARM, CTRDEC_LOAD, CTRDEC_LDARM,
      CTRDEC_DISSAVE, CTRDEC_SAVE, CTRDEC_DISARM, CTRDEC_SETTOG,
      CTRDEC_CLRTOG, CTRDEC_STEP, CTRDEC_SEQOFF, CTRDEC_SEQON
   } ctrdec_cmd_e;
endpackage

// ### ctrdec_properties.sv
// ctrdec_properties.sv - port-level assertions for the command decoder
// assumes: bound to ctrdec_top, one clock, synchronous active-low reset
`timescale 1ns/1ns
`include "ctrdec_defines.svh"

module ctrdec_properties #(
   parameter int NUM_CTR = 5
) (
   // clock and reset
   input wire logic                     ref_clk,
   input wire logic                     resetn,
   // apb slave side
   input wire logic [7:0]               paddr,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [31:0]              pwdata,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   // decoder outputs
   input wire logic                     pointer_autoadvance_off,
   input wire ctrdec_pkg::ctrdec_dptr_s dptr
);
   import ctrdec_pkg::*;
   // ==========================================================
   // access decode
   logic acc, cmd_wr, mm_wr, ptr_cmd, ptr_ok;
   assign acc     = psel && penable;
   assign cmd_wr  = acc && pwrite && paddr == `CTRDEC_OFS_CMD;
   assign mm_wr   = acc && pwrite && paddr == `CTRDEC_OFS_MMODE;
   assign ptr_cmd = cmd_wr && pwdata[7:5] == `CTRDEC_OP_PTR;
   assign ptr_ok  = ptr_cmd && pwdata[2:0] != `CTRDEC_GRP_BAD_A
                    && pwdata[2:0] != `CTRDEC_GRP_BAD_B;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ==========================================================
   // assertions
   seq_off_sets_a : assert property (
      cmd_wr && pwdata[7:0] == 8'hE8 |=> pointer_autoadvance_off)
      else $error("sequencing-off left autoadvance bit low");
   seq_on_clears_a : assert property (
      cmd_wr && pwdata[7:0] == 8'hE0 |=> !pointer_autoadvance_off)
      else $error("sequencing-on left autoadvance bit high");
   mm_write_bit_a : assert property (
      mm_wr |=> pointer_autoadvance_off == $past(pwdata[14]))
      else $error("master mode write missed autoadvance bit");
   autoadv_cause_a : assert property (
      $changed(pointer_autoadvance_off) |-> !$past(resetn) || $past(mm_wr)
      || $past(cmd_wr && pwdata[7:4] == 4'hE && pwdata[2:0] == 3'h0))
      else $error("autoadvance bit moved without a cause");
   ptr_bad_group_a : assert property (
      ptr_cmd && !ptr_ok |=> $stable(dptr))
      else $error("excluded group code changed the pointer");
   ptr_load_a : assert property (
      ptr_ok |=> dptr == {1'b1, $past(pwdata[4:0])})
      else $error("pointer load gave wrong fields");
   ptr_cause_a : assert property (
      $changed(dptr) |-> !$past(resetn) || $past(ptr_ok))
      else $error("pointer changed without a pointer load");
   mm_read_a : assert property (
      acc && !pwrite && paddr == `CTRDEC_OFS_MMODE
      |-> prdata[31:16] == 16'h0000
      && prdata[14] == pointer_autoadvance_off)
      else $error("master mode read disagrees with autoadvance bit");
   bad_addr_a : assert property (
      acc && paddr[1:0] != 2'b00
      |-> pready && pslverr && prdata == 32'h0000_0000)
      else $error("unaligned access not refused");
endmodule

bind ctrdec_top ctrdec_properties #(.NUM_CTR(NUM_CTR)) u_props (
   .ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .dptr(dptr),
   .pointer_autoadvance_off(pointer_autoadvance_off)
);

// ### ctrdec_host_model.sv
// ctrdec_host_model.sv - host processor issuing apb transfers
// assumes: slave clocked by ref_clk, answers within 16 cycles
`timescale 1ns/1ns

module ctrdec_host_model (
   // clock
   input  wire logic        ref_clk,
   // apb master side
   output logic [7:0]       paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // idle bus from time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
   end

   // one transfer after a random idle gap; counting is synchronous
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e, output bit ok);
      int n;
      repeat ($urandom_range(0, 2)) @(posedge ref_clk);
      @(posedge ref_clk);
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      psel   <= 1'b1;
      @(posedge ref_clk);
      penable <= 1'b1;
      ok = 1'b0;
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge ref_clk);
         ok = (pready === 1'b1);
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ### counter_command_decoder_tb.sv
// counter_command_decoder_tb.sv - self-checking bench for ctrdec_top
// assumes: host model drives apb, bench drives counter inputs
`timescale 1ns/1ns
`include "ctrdec_defines.svh"

module counter_command_decoder_tb;
   import ctrdec_pkg::*;
   logic         ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, rv;
   logic [4:0]   src_edge, gate_in, ctr_out;
   logic         pointer_autoadvance_off, ev;
   ctrdec_dptr_s dptr;
   logic [15:0]  ld [1:5], cnt [1:5], hld [1:5];
   int           err_total, tests_run;

   ctrdec_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_edge(src_edge), .gate_in(gate_in), .ctr_out(ctr_out),
      .pointer_autoadvance_off(pointer_autoadvance_off), .dptr(dptr));
   ctrdec_host_model u_host (.ref_clk(ref_clk), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   // ==========================================================
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // helpers
   function automatic logic [7:0] slot(input int n, input logic [1:0] w);
      return 8'(n * 16) + {4'h0, w, 2'b00};
   endfunction
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
      bit ok;
      u_host.xfer(a, w, d, rv, ev, ok);
      if (!ok) begin
         err_total++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic cmd(input logic [7:0] c);
      xfer(`CTRDEC_OFS_CMD, 1'b1, {24'h00_0000, c});
   endtask
   task automatic rchk(input string s, input logic [7:0] a,
                       input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0000_0000);
      check(s, rv, exp);
   endtask
   // count pulse on every counter, random gate levels
   task automatic pulse();
      @(posedge ref_clk);
      src_edge <= 5'h1F;
      gate_in  <= 5'($urandom);
      @(posedge ref_clk);
      src_edge <= 5'h00;
   endtask
   task automatic verify_all();
      for (int n = 1; n <= 5; n++) begin
         rchk("count", slot(n, `CTRDEC_SLOT_CNT), {16'h0000, cnt[n]});
         rchk("hold", slot(n, `CTRDEC_SLOT_HOLD), {16'h0000, hld[n]});
         rchk("load", slot(n, `CTRDEC_SLOT_LOAD), {16'h0000, ld[n]});
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      int n;
      logic [7:0] m;
      logic [1:0] e;
      logic [31:0] mm;
      ctrdec_dptr_s dp;
      void'($urandom(32'h9317));
      err_total = 0;
      tests_run = 0;
      resetn = 1'b0;
      src_edge = 5'h00;
      gate_in = 5'h00;
      for (n = 1; n <= 5; n++) begin
         ld[n] = 16'h0000;
         cnt[n] = 16'h0000;
         hld[n] = 16'h0000;
      end
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      rchk("mmode", `CTRDEC_OFS_MMODE, 32'h0000_0000);
      // random-mask load, then save all
      m = 8'h40 | (8'($urandom) & 8'h1F);
      for (n = 1; n <= 5; n++) begin
         ld[n] = 16'($urandom) | 16'h0010;
         wr(slot(n, `CTRDEC_SLOT_LOAD), {16'h0000, ld[n]});
         if (m[n-1]) cnt[n] = ld[n];
      end
      cmd(m);
      verify_all();
      cmd(8'hBF);
      hld = cnt;
      verify_all();
      // step every number, counter two counting up
      wr(slot(2, `CTRDEC_SLOT_MODE), 32'h0000_0008);
      for (n = 0; n <= 7; n++) begin
         cmd(8'hF0 | 8'(n));
         if (n == 2) cnt[2]++;
         else if (n >= 1 && n <= 5) cnt[n]--;
      end
      verify_all();
      // arm, disarm, disarm-and-save on counter three
      wr(slot(3, `CTRDEC_SLOT_LOAD), 32'h0000_0100);
      ld[3] = 16'h0100;
      cnt[3] = 16'h0100;
      cmd(8'h44);
      cmd(8'h24);
      rchk("stat", `CTRDEC_OFS_STAT, 32'h0000_0004);
      cmd(8'hC4);
      pulse();
      cmd(8'h24);
      pulse();
      cnt[3]--;
      cmd(8'h84);
      hld[3] = cnt[3];
      pulse();
      rchk("stat", `CTRDEC_OFS_STAT, 32'h0000_0000);
      verify_all();
      // load-and-arm counter one
      cmd(8'h61);
      cnt[1] = ld[1];
      rchk("stat", `CTRDEC_OFS_STAT, 32'h0000_0001);
      cmd(8'hC1);
      // load into terminal count and out again on counter four
      wr(slot(4, `CTRDEC_SLOT_LOAD), 32'h0000_0001);
      ld[4] = 16'h0001;
      cnt[4] = 16'h0001;
      cmd(8'h48);
      rchk("stat", `CTRDEC_OFS_STAT, 32'h0000_0000);
      cmd(8'h48);
      rchk("stat", `CTRDEC_OFS_STAT, 32'h0000_2100);
      cmd(8'h48);
      rchk("stat", `CTRDEC_OFS_STAT, 32'h0000_2000);
      verify_all();
      // deferred disarm in terminal count, counter four
      cmd(8'h28);
      cmd(8'h48);
      cmd(8'hC8);
      rchk("stat", `CTRDEC_OFS_STAT, 32'h0000_0108);
      pulse();
      rchk("stat", `CTRDEC_OFS_STAT, 32'h0000_0000);
      rchk("count", slot(4, `CTRDEC_SLOT_CNT), 32'h0000_0000);
      // alternating reload on counter four, hold first after arm
      wr(slot(4, `CTRDEC_SLOT_MODE), 32'h0000_0020);
      wr(slot(4, `CTRDEC_SLOT_HOLD), 32'h0000_0055);
      cmd(8'h68);
      cmd(8'h48);
      rchk("count", slot(4, `CTRDEC_SLOT_CNT), 32'h0000_0055);
      cmd(8'h48);
      rchk("count", slot(4, `CTRDEC_SLOT_CNT), 32'h0000_0001);
      cmd(8'h48);
      cmd(8'h48);
      rchk("count", slot(4, `CTRDEC_SLOT_CNT), 32'h0000_0055);
      cmd(8'hC8);
      // toggles, odd counters in toggle output mode
      for (n = 1; n <= 5; n++) begin
         wr(slot(n, `CTRDEC_SLOT_MODE), n[0] ? 32'h0000_0002 : 32'h0000_0000);
         cmd(8'hE0 | 8'(n));
      end
      for (n = 1; n <= 5; n++) cmd(8'hE8 | 8'(n));
      rchk("stat", `CTRDEC_OFS_STAT, 32'h0000_7C00);
      repeat (3) @(posedge ref_clk);
      check("ctr_out", {27'h0, ctr_out}, 32'h0000_0015);
      for (n = 1; n <= 5; n++) cmd(8'hE0 | 8'(n));
      rchk("stat", `CTRDEC_OFS_STAT, 32'h0000_0000);
      check("ctr_out", {27'h0, ctr_out}, 32'h0000_0000);
      // pointer load over every group code
      dp = '0;
      for (n = 0; n <= 7; n++) begin
         e = 2'($urandom);
         cmd({3'b000, e, 3'(n)});
         if (n != 0 && n != 6) dp = {1'b1, e, 3'(n)};
         @(posedge ref_clk);
         check("dptr", 32'(dptr), 32'(dp));
      end
      rchk("dptr", `CTRDEC_OFS_DPTR, 32'(dp));
      // master mode word and sequencing bit commands
      mm = {16'h0000, 16'($urandom)};
      wr(`CTRDEC_OFS_MMODE, mm);
      rchk("mmode", `CTRDEC_OFS_MMODE, mm);
      cmd(8'hE8);
      rchk("mmode", `CTRDEC_OFS_MMODE, mm | 32'h0000_4000);
      check("autoadv", 32'(pointer_autoadvance_off), 32'h0000_0001);
      cmd(8'hE0);
      rchk("mmode", `CTRDEC_OFS_MMODE, mm & 32'h0000_BFFF);
      xfer(8'h03, 1'b0, 32'h0000_0000);
      check("pslverr", 32'(ev), 32'h0000_0001);
      check("prdata", rv, 32'h0000_0000);
      give_verdict();
   end
endmodule
